// File: verilog/cspc_core_regs.v
// Core status, option, interrupt, power and program counter registers
// Function
// - Flag-updating writes keep ALU flags
// - Watchdog and sleep flags hardware-only
// - Two-bit bank select picks data bank
// - Zero flag reflects zero result
// - Half carry from bit three
// - Carry from top bit, inverted borrow
// - Rotates load carry from shifted bit
// - Pull-up disable bit gates pull-ups
// - Edge select picks external interrupt edge
// - Timer clock and edge selects
// - Prescaler assignment bit
// - Prescaler rate doubling per step
// - Flags set regardless of enables
// - Global enable gates unmasked interrupts
// - Timer and external flags software-cleared
// - Port change flag software-cleared
// - Power status bit cleared at power-up
// - Thirteen-bit counter cleared by reset
// - Upper counter from holding latch
// - Stack pushes and pops counter
// - Stack wraps, no overflow status
`timescale 1ns/100ps
`include "cspc_defines.vh"
module cspc_core_regs (
	input wire pclk,
	input wire presetn,
	input wire por_event,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output wire pready,
	output reg [31:0] prdata,
	output wire pslverr,
	input wire [2:0] pc_op,
	input wire [10:0] pc_target,
	input wire [1:0] alu_kind,
	input wire alu_sub,
	input wire alu_rot_left,
	input wire [7:0] alu_a,
	input wire [7:0] alu_b,
	input wire clear_watchdog_instr,
	input wire sleep_instr,
	input wire watchdog_expiry,
	input wire timer_overflow,
	input wire ext_irq_pin,
	input wire [3:0] upper_port_pins,
	input wire [3:0] port_dir_in,
	input wire [3:0] port_read_latch,
	input wire port_read,
	output reg [7:0] alu_result,
	output reg [12:0] pc,
	output reg [1:0] bank_select,
	output reg pullup_disable,
	output reg timer_clock_select,
	output reg timer_edge_select,
	output reg prescaler_target,
	output reg [2:0] prescaler_rate,
	output reg [8:0] timer_div,
	output reg [7:0] watchdog_div,
	output reg irq_request
);
	reg [7:0] status_r;
	reg [7:0] option_r;
	reg [7:0] intfl_r;
	reg pwr_r;
	reg [4:0] holding_r;
	reg [12:0] pc_r;
	reg ext_prev_r;
	reg [3:0] port_prev_r;
	reg [7:0] status_nxt;
	reg [7:0] intfl_nxt;
	reg [12:0] pc_nxt;
	reg [8:0] sum9;
	reg [4:0] sum5;
	reg [7:0] rot;
	reg rot_c;
	wire [12:0] stack_top;
	wire acc = psel & penable;
	wire wr = acc & pwrite;
	wire [7:0] wb = pwdata[7:0];
	wire ext_edge;
	wire port_change;
	wire stack_push = (pc_op == `CSPC_OP_CALL) || (pc_op == `CSPC_OP_IRQ);
	wire stack_pop = (pc_op == `CSPC_OP_RET);
	wire mapped;

	// ---------------------------------------------
	// Bus slave
	// ---------------------------------------------
	assign pready = 1'b1;
	assign mapped = (paddr == `CSPC_ADDR_STATUS) || (paddr == `CSPC_ADDR_PCL) ||
		(paddr == `CSPC_ADDR_PC_UPPER_HOLDING) || (paddr == `CSPC_ADDR_INTFL) ||
		(paddr == `CSPC_ADDR_OPTION) || (paddr == `CSPC_ADDR_PWR) ||
		(paddr == `CSPC_ADDR_PC_STATE);
	assign pslverr = acc & ~mapped;

	always @*
	begin
		case (paddr)
			`CSPC_ADDR_STATUS: prdata = {24'h000000, status_r};
			`CSPC_ADDR_PCL: prdata = {24'h000000, pc_r[7:0]};
			`CSPC_ADDR_PC_UPPER_HOLDING: prdata = {27'h0000000, holding_r};
			`CSPC_ADDR_INTFL: prdata = {24'h000000, intfl_r};
			`CSPC_ADDR_OPTION: prdata = {24'h000000, option_r};
			`CSPC_ADDR_PWR: prdata = {30'h00000000, pwr_r, 1'b0};
			`CSPC_ADDR_PC_STATE: prdata = {19'h00000, pc_r};
			default: prdata = 32'h00000000;
		endcase
	end

	// ---------------------------------------------
	// ALU flag logic
	// ---------------------------------------------
	always @*
	begin
		sum9 = {1'b0, alu_a} + (alu_sub ? {1'b0, ~alu_b} + 9'h001 : {1'b0, alu_b});
		sum5 = {1'b0, alu_a[3:0]} + (alu_sub ? {1'b0, ~alu_b[3:0]} + 5'h01 : {1'b0, alu_b[3:0]});
		rot = alu_rot_left ? {alu_a[6:0], status_r[`CSPC_ST_CARRY]} :
			{status_r[`CSPC_ST_CARRY], alu_a[7:1]};
		rot_c = alu_rot_left ? alu_a[7] : alu_a[0];
		case (alu_kind)
			`CSPC_ALU_ARITH: alu_result = sum9[7:0];
			`CSPC_ALU_ROT: alu_result = rot;
			default: alu_result = alu_a;
		endcase
	end

	always @*
	begin
		status_nxt = status_r;
		if (wr && paddr == `CSPC_ADDR_STATUS)
		begin
			// Hardware-only flags stay; all three ALU flags ignore the write during any ALU op
			status_nxt[7:5] = wb[7:5];
			if (alu_kind == `CSPC_ALU_NONE)
				status_nxt[2:0] = wb[2:0];
		end
		case (alu_kind)
			`CSPC_ALU_ZERO:
				status_nxt[`CSPC_ST_ZERO] = (alu_a == 8'h00);
			`CSPC_ALU_ARITH:
			begin
				status_nxt[`CSPC_ST_ZERO] = (sum9[7:0] == 8'h00);
				status_nxt[`CSPC_ST_HALF] = sum5[4];
				status_nxt[`CSPC_ST_CARRY] = sum9[8];
			end
			`CSPC_ALU_ROT:
				status_nxt[`CSPC_ST_CARRY] = rot_c;
			default:
				status_nxt[`CSPC_ST_CARRY] = status_nxt[`CSPC_ST_CARRY];
		endcase
		// Sleep and clear-watchdog win over an expiry in the same cycle
		if (clear_watchdog_instr)
		begin
			status_nxt[`CSPC_ST_WDEXP] = 1'b1;
			status_nxt[`CSPC_ST_SLEEP] = 1'b1;
		end
		else if (sleep_instr)
		begin
			status_nxt[`CSPC_ST_WDEXP] = 1'b1;
			status_nxt[`CSPC_ST_SLEEP] = 1'b0;
		end
		else if (watchdog_expiry)
			status_nxt[`CSPC_ST_WDEXP] = 1'b0;
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			status_r <= 8'h18;
		else if (por_event)
			status_r <= 8'h18;
		else
			status_r <= status_nxt;
	end

	// ---------------------------------------------
	// Option register
	// ---------------------------------------------
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			option_r <= `CSPC_OPT_RESET;
		// Power-up event restores the reset value, like the pin reset
		else if (por_event)
			option_r <= `CSPC_OPT_RESET;
		else if (wr && paddr == `CSPC_ADDR_OPTION)
			option_r <= wb;
	end

	always @*
	begin
		pullup_disable = option_r[7];
		timer_clock_select = option_r[5];
		timer_edge_select = option_r[4];
		prescaler_target = option_r[3];
		prescaler_rate = option_r[2:0];
		bank_select = status_r[6:5];
		// Timer direct when prescaler is on the watchdog
		timer_div = option_r[3] ? 9'h001 : (9'h002 << option_r[2:0]);
		watchdog_div = option_r[3] ? (8'h01 << option_r[2:0]) : 8'h01;
	end

	// ---------------------------------------------
	// Interrupt flags
	// ---------------------------------------------
	// Edge select: one rising, zero falling
	assign ext_edge = option_r[6] ? (ext_irq_pin & ~ext_prev_r) : (~ext_irq_pin & ext_prev_r);
	// Mismatch against the latch from the last port read, inputs only
	assign port_change = |((upper_port_pins ^ port_prev_r) & port_dir_in);

	always @*
	begin
		intfl_nxt = intfl_r;
		if (wr && paddr == `CSPC_ADDR_INTFL)
			intfl_nxt = {wb[7], 1'b0, wb[5:0]};
		// Sets win over a software clear
		if (timer_overflow)
			intfl_nxt[`CSPC_INT_TF] = 1'b1;
		if (ext_edge)
			intfl_nxt[`CSPC_INT_EF] = 1'b1;
		if (port_change)
			intfl_nxt[`CSPC_INT_PF] = 1'b1;
		// Hardware clears the global enable on the vector branch
		if (pc_op == `CSPC_OP_IRQ)
			intfl_nxt[`CSPC_INT_GIE] = 1'b0;
		else if (stack_pop && pc_target[0])
			intfl_nxt[`CSPC_INT_GIE] = 1'b1;
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			intfl_r <= 8'h00;
			ext_prev_r <= 1'b0;
			port_prev_r <= 4'h0;
		end
		else
		begin
			// Power-up event clears enables and flags together
			intfl_r <= por_event ? 8'h00 : intfl_nxt;
			ext_prev_r <= ext_irq_pin;
			if (port_read)
				port_prev_r <= port_read_latch;
		end
	end

	always @*
	begin
		irq_request = intfl_r[`CSPC_INT_GIE] &
			|(intfl_r[5:3] & intfl_r[2:0]);
	end

	// ---------------------------------------------
	// Power status
	// ---------------------------------------------
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pwr_r <= 1'b0;
		else if (por_event)
			pwr_r <= 1'b0;
		else if (wr && paddr == `CSPC_ADDR_PWR)
			pwr_r <= wb[`CSPC_PWR_BIT];
	end

	// ---------------------------------------------
	// Program counter and holding latch
	// ---------------------------------------------
	always @*
	begin
		pc_nxt = pc_r;
		case (pc_op)
			`CSPC_OP_INC: pc_nxt = pc_r + 13'h0001;
			`CSPC_OP_CALL, `CSPC_OP_GOTO: pc_nxt = {holding_r[4:3], pc_target};
			`CSPC_OP_RET: pc_nxt = stack_top;
			`CSPC_OP_IRQ: pc_nxt = `CSPC_IRQ_VECTOR;
			default: pc_nxt = pc_r;
		endcase
		if (wr && paddr == `CSPC_ADDR_PCL)
			pc_nxt = {holding_r, wb};
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pc_r <= 13'h0000;
			holding_r <= 5'h00;
		end
		else if (por_event)
		begin
			pc_r <= 13'h0000;
			holding_r <= 5'h00;
		end
		else
		begin
			pc_r <= pc_nxt;
			if (wr && paddr == `CSPC_ADDR_PC_UPPER_HOLDING)
				holding_r <= wb[4:0];
		end
	end

	always @*
	begin
		pc = pc_r;
	end

	// Return address is the next instruction
	cspc_return_stack u_stack (
		.pclk(pclk),
		.presetn(presetn),
		.push(stack_push),
		.pop(stack_pop),
		.push_data(pc_r + 13'h0001),
		.top_data(stack_top)
	);
endmodule // cspc_core_regs

// File: verilog/cspc_defines.vh
// Offsets, field positions, reset values for the core status/control block
`ifndef CSPC_DEFINES_VH
`define CSPC_DEFINES_VH
`define CSPC_ADDR_STATUS 12'h00c
`define CSPC_ADDR_PCL 12'h008
`define CSPC_ADDR_PC_UPPER_HOLDING 12'h028
`define CSPC_ADDR_INTFL 12'h02c
`define CSPC_ADDR_OPTION 12'h204
`define CSPC_ADDR_PWR 12'h238
`define CSPC_ADDR_CORE_CTRL 12'h400
`define CSPC_ADDR_PC_STATE 12'h404
`define CSPC_ADDR_EVENT 12'h408
`define CSPC_IDX_STATUS 8'h03
`define CSPC_IDX_PCL 8'h02
`define CSPC_IDX_PC_UPPER_HOLDING 8'h0a
`define CSPC_IDX_INTFL 8'h0b
`define CSPC_IDX_OPTION 8'h81
`define CSPC_IDX_PWR 8'h8e
`define CSPC_ST_CARRY 0
`define CSPC_ST_HALF 1
`define CSPC_ST_ZERO 2
`define CSPC_ST_SLEEP 3
`define CSPC_ST_WDEXP 4
`define CSPC_ST_BANK_LO 5
`define CSPC_ST_BANK_HI 6
`define CSPC_ST_IND 7
`define CSPC_OPT_RESET 8'hff
`define CSPC_INT_GIE 7
`define CSPC_INT_TIE 5
`define CSPC_INT_EIE 4
`define CSPC_INT_PIE 3
`define CSPC_INT_TF 2
`define CSPC_INT_EF 1
`define CSPC_INT_PF 0
`define CSPC_PWR_BIT 1
`define CSPC_STACK_DEPTH 8
`define CSPC_PC_W 13
`define CSPC_OP_NONE 3'h0
`define CSPC_OP_CALL 3'h1
`define CSPC_OP_GOTO 3'h2
`define CSPC_OP_RET 3'h3
`define CSPC_OP_IRQ 3'h4
`define CSPC_OP_INC 3'h5
`define CSPC_IRQ_VECTOR 13'h0004
`define CSPC_ALU_NONE 2'h0
`define CSPC_ALU_ZERO 2'h1
`define CSPC_ALU_ARITH 2'h2
`define CSPC_ALU_ROT 2'h3
`endif

// File: verilog/cspc_return_stack.v
// Eight-entry circular return stack
`timescale 1ns/100ps
`include "cspc_defines.vh"
module cspc_return_stack (
	input wire pclk,
	input wire presetn,
	input wire push,
	input wire pop,
	input wire [12:0] push_data,
	output wire [12:0] top_data
);
	reg [12:0] mem [0:`CSPC_STACK_DEPTH-1];
	reg [2:0] ptr_r;
	wire [2:0] below = ptr_r - 3'h1;
	genvar i;
	// ---------------------------------------------
	// Entries
	// ---------------------------------------------
	generate
		for (i = 0; i < `CSPC_STACK_DEPTH; i = i + 1)
		begin : g_ent
			always @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					mem[i] <= 13'h0000;
				else if (push && ptr_r == i)
					mem[i] <= push_data;
			end
		end
	endgenerate
	// Pointer wraps silently, no overflow flag
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ptr_r <= 3'h0;
		else if (push)
			ptr_r <= ptr_r + 3'h1;
		else if (pop)
			ptr_r <= below;
	end
	assign top_data = mem[below];
endmodule // cspc_return_stack

// File: tb/cspc_core_model.sv
// Instruction core stand-in driving program counter operations
`timescale 1ns/100ps
module cspc_core_model (
	input wire pclk,
	input wire presetn,
	input wire [2:0] op_req,
	input wire [10:0] tgt_req,
	output reg [2:0] pc_op,
	output reg [10:0] pc_target
);
// Idle target toggles so a stale value is never mistaken for a live one
always @(posedge pclk or negedge presetn)
	if (!presetn)
	begin
		pc_op <= 3'h0;
		pc_target <= 11'h000;
	end
	else
	begin
		pc_op <= op_req;
		pc_target <= (op_req == 3'h0) ? ~pc_target : tgt_req;
	end
endmodule // cspc_core_model

// File: tb/cspc_core_regs_monitor.sv
// Concurrent checks on the core register block ports
`timescale 1ns/100ps
module cspc_core_regs_monitor (
	input wire pclk,
	input wire presetn,
	input wire por_event,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [2:0] pc_op,
	input wire [10:0] pc_target,
	input wire [1:0] alu_kind,
	input wire alu_sub,
	input wire [7:0] alu_a,
	input wire [7:0] alu_b,
	input wire [7:0] alu_result,
	input wire [12:0] pc,
	input wire [1:0] bank_select,
	input wire pullup_disable,
	input wire timer_clock_select,
	input wire timer_edge_select,
	input wire prescaler_target,
	input wire [2:0] prescaler_rate,
	input wire [8:0] timer_div,
	input wire [7:0] watchdog_div,
	input wire irq_request
);
wire wr = psel && penable && pwrite;
default clocking @(posedge pclk); endclocking
default disable iff (!presetn);
sequence s_call_ret;
	pc_op == 3'h1 && !wr ##1 pc_op == 3'h0 [*2] ##1 pc_op == 3'h3 && !wr;
endsequence
property p_bank;
	wr && paddr == 12'h00c |=> bank_select == $past(pwdata[6:5]);
endproperty
property p_option;
	wr && paddr == 12'h204 |=> {pullup_disable, timer_clock_select, timer_edge_select, prescaler_target,
		prescaler_rate} == {$past(pwdata[7]), $past(pwdata[5:0])};
endproperty
property p_tdiv;
	$stable({prescaler_target, prescaler_rate}) |-> timer_div == (prescaler_target ? 9'h001 : 9'h002 << prescaler_rate);
endproperty
property p_wdiv;
	$stable({prescaler_target, prescaler_rate}) |-> watchdog_div == (prescaler_target ? 8'h01 << prescaler_rate : 8'h01);
endproperty
property p_call_ret;
	s_call_ret |=> pc == $past(pc, 4) + 13'h1;
endproperty
property p_irq;
	pc_op == 3'h4 && !wr |=> pc == 13'h0004 && !irq_request;
endproperty
property p_goto;
	pc_op == 3'h2 && !wr |=> pc[10:0] == $past(pc_target);
endproperty
property p_por;
	por_event |=> pc == 13'h0000;
endproperty
property p_alu;
	alu_kind == 2'h2 |-> alu_result == (alu_sub ? alu_a - alu_b : alu_a + alu_b);
endproperty
a_bank: assert property (p_bank) else $error("bank select not loaded");
a_option: assert property (p_option) else $error("option outputs wrong");
a_tdiv: assert property (p_tdiv) else $error("timer divider wrong");
a_wdiv: assert property (p_wdiv) else $error("watchdog divider wrong");
a_call_ret: assert property (p_call_ret) else $error("return address wrong");
a_irq: assert property (p_irq) else $error("interrupt branch wrong");
a_goto: assert property (p_goto) else $error("jump target wrong");
a_por: assert property (p_por) else $error("counter not cleared");
a_alu: assert property (p_alu) else $error("arithmetic result wrong");
endmodule // cspc_core_regs_monitor

// File: tb/test_cspc_core_regs.sv
// Self-checking bench for the core status and control registers
`timescale 1ns/100ps
module test_cspc_core_regs;
logic pclk = 0, presetn = 0, por_event = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, errv;
logic alu_sub = 0, alu_rot_left = 0, clear_watchdog_instr = 0, sleep_instr = 0, watchdog_expiry = 0;
logic timer_overflow = 0, ext_irq_pin = 0, port_read = 0, pullup_disable, timer_clock_select;
logic timer_edge_select, prescaler_target, irq_request;
logic [11:0] paddr = 0;
logic [31:0] pwdata = 0, prdata, rdv;
logic [2:0] op_req = 0, pc_op, prescaler_rate;
logic [10:0] tgt_req = 0, pc_target;
logic [1:0] alu_kind = 0, bank_select;
logic [7:0] alu_a = 0, alu_b = 0, alu_result, watchdog_div;
logic [3:0] upper_port_pins = 0, port_dir_in = 4'hf, port_read_latch = 0;
logic [12:0] pc;
logic [8:0] timer_div;
int miscompares = 0, n_compared = 0, k;
always #12.5 pclk = ~pclk;
cspc_core_regs i_cspc_core_regs (.*);
cspc_core_model i_cspc_core_model (.*);
task chk(input logic [31:0] g, input logic [31:0] e);
	n_compared++;
	if (g !== e)
	begin
		miscompares++;
		$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
	end
endtask
// Zero wait states expected, but the wait is bounded rather than assumed
task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
	int n;
	@(posedge pclk);
	psel <= 1;
	pwrite <= w;
	paddr <= a;
	pwdata <= d;
	@(posedge pclk);
	penable <= 1;
	n = 0;
	do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
	rdv = prdata;
	errv = pslverr;
	psel <= 0;
	penable <= 0;
	@(negedge pclk);
endtask
task rd(input logic [11:0] a, input logic [31:0] e);
	apb(0, a, 0);
	chk(rdv, e);
endtask
task alu(input logic [1:0] k, input logic s, input logic l, input logic [7:0] a, input logic [7:0] b);
	@(posedge pclk);
	alu_kind <= k;
	alu_sub <= s;
	alu_rot_left <= l;
	alu_a <= a;
	alu_b <= b;
	@(posedge pclk);
	alu_kind <= 0;
endtask
task op(input logic [2:0] o, input logic [10:0] t);
	@(posedge pclk);
	op_req <= o;
	tgt_req <= t;
	@(posedge pclk);
	op_req <= 0;
	@(posedge pclk);
endtask
task t_status();
	apb(1, 12'h00c, 32'h20);
	rd(12'h00c, 32'h38);
	alu(1, 0, 0, 8'h00, 8'h00);
	rd(12'h00c, 32'h3c);
	alu(2, 0, 0, 8'h0f, 8'h01);
	rd(12'h00c, 32'h3a);
	alu(2, 1, 0, 8'h10, 8'h10);
	rd(12'h00c, 32'h3f);
	alu(3, 0, 0, 8'h02, 8'h00);
	rd(12'h00c, 32'h3e);
	alu(3, 0, 1, 8'h80, 8'h00);
	rd(12'h00c, 32'h3f);
	@(posedge pclk);
	alu_kind <= 2;
	alu_a <= 8'hff;
	alu_b <= 8'h01;
	apb(1, 12'h00c, 32'h00);
	@(posedge pclk);
	alu_kind <= 0;
	rd(12'h00c, 32'h1f);
	@(posedge pclk) sleep_instr <= 1;
	@(posedge pclk) sleep_instr <= 0;
	rd(12'h00c, 32'h17);
	@(posedge pclk) watchdog_expiry <= 1;
	@(posedge pclk) watchdog_expiry <= 0;
	rd(12'h00c, 32'h07);
	@(posedge pclk) clear_watchdog_instr <= 1;
	@(posedge pclk) clear_watchdog_instr <= 0;
	rd(12'h00c, 32'h1f);
endtask
task t_option();
	apb(1, 12'h204, 32'h5a);
	rd(12'h204, 32'h5a);
	chk({pullup_disable, timer_clock_select, timer_edge_select, prescaler_target, prescaler_rate}, 32'h1a);
	chk({23'h0, timer_div}, 32'h1);
	chk({24'h0, watchdog_div}, 32'h4);
	apb(1, 12'h204, 32'hc7);
	chk({23'h0, timer_div}, 32'h100);
	chk({24'h0, watchdog_div}, 32'h1);
endtask
task t_irq();
	apb(1, 12'h02c, 32'h38);
	@(posedge pclk) timer_overflow <= 1;
	@(posedge pclk) timer_overflow <= 0;
	rd(12'h02c, 32'h3c);
	chk({31'h0, irq_request}, 32'h0);
	apb(1, 12'h02c, 32'hbc);
	chk({31'h0, irq_request}, 32'h1);
	@(posedge pclk) ext_irq_pin <= 1;
	rd(12'h02c, 32'hbe);
	@(posedge pclk) port_read <= 1;
	@(posedge pclk) port_read <= 0;
	upper_port_pins <= 4'h8;
	rd(12'h02c, 32'hbf);
	apb(1, 12'h02c, 32'hb8);
	rd(12'h02c, 32'hb9);
	@(posedge pclk);
	port_read_latch <= 4'h8;
	port_read <= 1;
	@(posedge pclk) port_read <= 0;
	apb(1, 12'h02c, 32'hb8);
	rd(12'h02c, 32'hb8);
	chk({31'h0, irq_request}, 32'h0);
endtask
task t_pc();
	apb(1, 12'h028, 32'h1f);
	apb(1, 12'h008, 32'h34);
	rd(12'h404, 32'h1f34);
	op(2, 11'h123);
	rd(12'h404, 32'h1923);
	for (k = 1; k <= 9; k++)
		op(1, 11'(11'h100 + k));
	for (k = 1; k <= 9; k++)
	begin
		op(3, 11'h0);
		rd(12'h404, (k == 9) ? 32'h1909 : 32'h1900 + 10 - k);
	end
	op(4, 11'h0);
	rd(12'h404, 32'h0004);
	rd(12'h02c, 32'h38);
	op(3, 11'h1);
	rd(12'h404, 32'h190a);
	rd(12'h02c, 32'hb8);
	rd(12'h028, 32'h1f);
endtask
task t_por();
	apb(1, 12'h238, 32'hff);
	rd(12'h238, 32'h2);
	@(posedge pclk) por_event <= 1;
	@(posedge pclk) por_event <= 0;
	rd(12'h238, 32'h0);
	rd(12'h00c, 32'h18);
	rd(12'h404, 32'h0);
	rd(12'h204, 32'hff);
	rd(12'h02c, 32'h0);
	rd(12'h100, 32'h0);
	chk({31'h0, errv}, 32'h1);
endtask
task end_sim();
	$display("compared %0d mismatched %0d", n_compared, miscompares);
	if (miscompares == 0 && n_compared > 0)
		$display("[ PASS ]");
	else
		$display("[ FAIL ]");
	$finish;
endtask
initial
begin
	repeat (5) @(posedge pclk);
	presetn <= 1;
	t_status();
	t_option();
	t_irq();
	t_pc();
	t_por();
	end_sim();
end
initial
begin
	repeat (5000) @(posedge pclk);
	miscompares++;
	end_sim();
end
endmodule // test_cspc_core_regs
bind cspc_core_regs cspc_core_regs_monitor i_cspc_core_regs_monitor (.*);
